// *** core/sap_pkg.sv ***
// constants shared by both ends of the stack arithmetic host port
// assumes a 125 MHz pclk on both ends
package sap_pkg;
    // ----------------------------------------
    // clocking and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int EXEC_TIME_NS  = 128;  // fixed execution time of every command
    localparam int EXEC_CYC      = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] EXEC_CNT = 8'(EXEC_CYC - 1);

    // ----------------------------------------
    // stack geometry
    // ----------------------------------------
    localparam int STACK_BYTES = 16;     // eight 16-bit or four 32-bit entries
    localparam int PTR_W       = 4;
    localparam logic [3:0] PTR_RST = 4'h0;

    // ----------------------------------------
    // command encodings (low seven bits; bit 7 asks for service request)
    // ----------------------------------------
    localparam int SRQ_BIT = 7;
    localparam logic [6:0] OP_NOP  = 7'h00;
    localparam logic [6:0] OP_SADD = 7'h6c;
    localparam logic [6:0] OP_SSUB = 7'h6d;
    localparam logic [6:0] OP_SMUL = 7'h6e;
    localparam logic [6:0] OP_SDIV = 7'h6f;
    localparam logic [6:0] OP_SMUU = 7'h76;
    localparam logic [6:0] OP_DADD = 7'h2c;
    localparam logic [6:0] OP_DSUB = 7'h2d;
    localparam logic [6:0] OP_CHSF = 7'h15;

    // ----------------------------------------
    // status byte layout and error codes
    // ----------------------------------------
    localparam int ST_BUSY  = 7;
    localparam int ST_SIGN  = 6;
    localparam int ST_ZERO  = 5;
    localparam int ST_ERR_L = 1;
    localparam int ST_CARRY = 0;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_DIV0 = 4'h8;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // ----------------------------------------
    // floating point word layout
    // ----------------------------------------
    localparam int FP_SIGN = 31;

    // ----------------------------------------
    // controller register map (apb byte addresses)
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;  // [0] cmd/data [1] read [15:8] byte; write starts
    localparam logic [7:0] REG_STAT = 8'h04;  // [0] busy [15:8] read byte [16] end_n [17] svc
    localparam int CTRL_CD  = 0;
    localparam int CTRL_RD  = 1;
    localparam int CTRL_B_L = 8;
    localparam int STAT_END = 16;
    localparam int STAT_SVC = 17;
endpackage

// *** core/sap_link_if.sv ***
// byte bus between the host controller and the coprocessor port
// the shared byte lane is resolved here from the two output enables
`timescale 1ns/1ps
interface sap_link_if;
    logic       cs_n;
    logic       cd;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] host_dout;
    logic       host_oe_n;
    logic [7:0] dev_dout;
    logic       dev_oe_n;
    logic [7:0] host_byte_bus;
    logic       ack_n;
    logic       end_n;
    logic       service_request;

    // device drive wins, else host drive, else pulled high
    assign host_byte_bus = !dev_oe_n ? dev_dout : (!host_oe_n ? host_dout : 8'hff);

    modport dev  (input cs_n, cd, rd_n, wr_n, host_byte_bus,
                  output dev_dout, dev_oe_n, ack_n, end_n, service_request);
    modport host (input host_byte_bus, ack_n, end_n, service_request,
                  output cs_n, cd, rd_n, wr_n, host_dout, host_oe_n);
endinterface

// *** core/sap_dev.sv ***
// coprocessor end of the host port: handshake, byte stack, command execution
// assumes strobes already synchronous to pclk; host keeps its own protocol
//
// Notes on behaviour
// RQ1: command write acknowledged low, then high
// RQ2: command during execution waits until done
// RQ3: result written to next, then popped
// RQ4: 16-bit and 32-bit operand sizes kept
// RQ5: host pushes least significant byte first
// RQ6: data push acknowledged low, then high
// RQ7: host pushes every byte of a quantity
// RQ8: stack holds sixteen bytes, overwrite wraps
// RQ9: pops deliver most significant byte first
// RQ10: data read byte held while read low
// RQ11: reading moves pointer only, wraps around
// RQ12: status readable any time, even busy
// RQ13: status read clears end of execution
// RQ14: fixed point is two's complement
// RQ15: floating mantissa is normalised fraction
// RQ16: angle operands are in radians
// RQ17: divide returns quotient, no remainder
// RQ18: bottom stack entry may be clobbered
// RQ19: host sends only defined command codes
// RQ20: float sign bit 31, zero all zeros
// RQ21: status busy sign zero error carry
// RQ22: acknowledge high unless selected strobe low
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module sap_dev
    import sap_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // link
    sap_link_if.dev   lnk
);
    // ----------------------------------------
    // types and state
    // ----------------------------------------
    typedef enum logic [0:0] {HS_IDLE, HS_DONE} sap_hs_t;

    sap_hs_t         hs_r;
    logic [7:0]      stk_r [STACK_BYTES];
    logic [PTR_W-1:0] ptr_r;
    logic [7:0]      rdata_r;
    logic [7:0]      cmd_r;
    logic            busy_r;
    logic [7:0]      cnt_r;
    logic            end_n_r;
    logic            svc_r;
    logic            sign_r;
    logic            zero_r;
    logic [3:0]      err_r;
    logic            carry_r;

    // ----------------------------------------
    // host side decode
    // ----------------------------------------
    wire wr_req   = !lnk.cs_n && !lnk.wr_n;
    wire rd_req   = !lnk.cs_n && !lnk.rd_n;
    wire any_req  = wr_req || rd_req;
    wire stat_rd  = rd_req && lnk.cd;
    // data and commands wait for a running command; status never waits
    wire take     = any_req && (hs_r == HS_IDLE) && (!busy_r || stat_rd);        // RQ2 RQ12
    wire do_cmd   = take && wr_req && lnk.cd;
    wire do_push  = take && wr_req && !lnk.cd;
    wire do_pop   = take && rd_req && !lnk.cd;
    wire [PTR_W-1:0] ptr_dn = ptr_r - PTR_W'(1);

    // acknowledge low from strobe until the transfer is served
    assign lnk.ack_n = !(any_req && (hs_r == HS_IDLE));                          // RQ1 RQ6 RQ10 RQ22
    // byte stays on the bus for as long as the read strobe is low
    assign lnk.dev_oe_n = !(rd_req && (hs_r == HS_DONE));                         // RQ10 RQ12
    assign lnk.dev_dout = rdata_r;
    assign lnk.end_n = end_n_r;
    assign lnk.service_request = svc_r;

    wire [7:0] status = {busy_r, sign_r, zero_r, err_r, carry_r};                // RQ21

    // ----------------------------------------
    // operand fetch: top is the last pushed entry, msb at ptr-1
    // ----------------------------------------
    wire [PTR_W-1:0] ix [8];
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_ix
            assign ix[g] = ptr_r - PTR_W'(g + 1);
        end
    endgenerate

    wire [15:0] top16 = {stk_r[ix[0]], stk_r[ix[1]]};
    wire [15:0] nxt16 = {stk_r[ix[2]], stk_r[ix[3]]};
    wire [31:0] top32 = {stk_r[ix[0]], stk_r[ix[1]], stk_r[ix[2]], stk_r[ix[3]]};
    wire [31:0] nxt32 = {stk_r[ix[4]], stk_r[ix[5]], stk_r[ix[6]], stk_r[ix[7]]};

    // ----------------------------------------
    // command decode and arithmetic
    // ----------------------------------------
    wire [6:0] op    = cmd_r[6:0];
    wire op_s2       = (op == OP_SADD) || (op == OP_SSUB) || (op == OP_SMUL)
                       || (op == OP_SDIV) || (op == OP_SMUU);
    wire op_d2       = (op == OP_DADD) || (op == OP_DSUB);
    wire op_f1       = (op == OP_CHSF);
    wire binop       = op_s2 || op_d2;                                            // RQ3
    wire div0        = (op == OP_SDIV) && (top16 == 16'h0000);

    // two's complement 16-bit results with carry/borrow
    wire [16:0] s_add  = {1'b0, nxt16} + {1'b0, top16};                          // RQ14
    wire [16:0] s_sub  = {1'b0, nxt16} - {1'b0, top16};
    // operands widened first so the upper product half survives
    wire [31:0] s_mul  = 32'($signed({{16{nxt16[15]}}, nxt16}) * $signed({{16{top16[15]}}, top16}));
    // quotient only; the remainder is discarded
    wire [15:0] s_quo  = div0 ? nxt16 : 16'($signed(nxt16) / $signed(top16));   // RQ17
    wire [32:0] d_add  = {1'b0, nxt32} + {1'b0, top32};
    wire [32:0] d_sub  = {1'b0, nxt32} - {1'b0, top32};
    // float sign change leaves the all-zero value untouched
    wire [31:0] f_chs  = (top32 == 32'h0000_0000) ? top32
                         : (top32 ^ (32'h0000_0001 << FP_SIGN));                  // RQ15 RQ20

    // result word, carry and size; trig codes are not executed, angles stay radians
    logic [31:0] res;
    logic        res_c;
    always_comb
    begin
        res   = 32'h0000_0000;
        res_c = 1'b0;
        unique case (1'b1)
            (op == OP_SADD): {res_c, res[15:0]} = s_add;
            (op == OP_SSUB): {res_c, res[15:0]} = s_sub;
            (op == OP_SMUL): res[15:0] = s_mul[15:0];
            (op == OP_SMUU): res[15:0] = s_mul[31:16];
            (op == OP_SDIV): res[15:0] = s_quo;
            (op == OP_DADD): {res_c, res} = d_add;
            (op == OP_DSUB): {res_c, res} = d_sub;
            op_f1:           res = f_chs;                                         // RQ16
            default:         res = 32'h0000_0000;                                 // RQ19
        endcase
    end

    wire        is32   = op_d2 || op_f1;                                          // RQ4
    wire [2:0]  nbytes = is32 ? 3'h4 : 3'h2;
    wire        writes = binop || op_f1;
    wire        sign_w = is32 ? res[31] : res[15];
    wire        zero_w = is32 ? (res == 32'h0000_0000) : (res[15:0] == 16'h0000);
    // result lsb lands at the next entry for binary ops, at top otherwise
    wire [PTR_W-1:0] base = binop ? (is32 ? ix[7] : ix[3]) : (is32 ? ix[3] : ix[1]);
    wire finish = busy_r && (cnt_r == 8'h00);

    // ----------------------------------------
    // handshake state
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hs_r <= HS_IDLE;
        else if (take)
            hs_r <= HS_DONE;
        else if (!any_req)
            hs_r <= HS_IDLE;
    end

    // ----------------------------------------
    // byte stack and pointer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ptr_r <= PTR_RST;
        else if (do_push)
            ptr_r <= ptr_r + PTR_W'(1);                                           // RQ5 RQ7 RQ8
        else if (do_pop)
            ptr_r <= ptr_dn;                                                      // RQ9 RQ11
        else if (finish && binop)
            ptr_r <= ptr_r - PTR_W'(nbytes);                                      // RQ3
    end

    // stack array has no reset; contents after reset are unspecified
    always_ff @(posedge pclk)
    begin
        if (do_push)
            stk_r[ptr_r] <= lnk.host_byte_bus;                                    // RQ8
        else if (finish && writes)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (3'(i) < nbytes)
                    stk_r[base + PTR_W'(i)] <= res[8*i +: 8];                     // RQ3 RQ18
            end
        end
    end

    // ----------------------------------------
    // read data latch
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_r <= 8'h00;
        else if (do_pop)
            rdata_r <= stk_r[ptr_dn];                                             // RQ9 RQ11
        else if (take && stat_rd)
            rdata_r <= status;                                                    // RQ12
    end

    // ----------------------------------------
    // command execution
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_r  <= 8'h00;
            busy_r <= 1'b0;
            cnt_r  <= 8'h00;
        end
        else if (do_cmd)
        begin
            cmd_r  <= lnk.host_byte_bus;
            busy_r <= 1'b1;
            cnt_r  <= EXEC_CNT;
        end
        else if (finish)
            busy_r <= 1'b0;                                                       // RQ2
        else if (busy_r)
            cnt_r <= cnt_r - 8'h01;
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {sign_r, zero_r, err_r, carry_r} <= STATUS_RST[6:0];
        else if (finish && writes)
        begin
            sign_r  <= sign_w;
            zero_r  <= zero_w;
            err_r   <= div0 ? ERR_DIV0 : ERR_NONE;
            carry_r <= res_c;
        end
        else if (finish)
            err_r <= ERR_NONE;
    end

    // ----------------------------------------
    // end of execution and service request
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            end_n_r <= 1'b1;
            svc_r   <= 1'b0;
        end
        else if (finish)
        begin
            end_n_r <= 1'b0;                                                      // completion wins
            svc_r   <= cmd_r[SRQ_BIT];
        end
        else if (do_cmd || (take && stat_rd))
        begin
            end_n_r <= 1'b1;                                                      // RQ13
            svc_r   <= do_cmd ? 1'b0 : svc_r;
        end
    end
endmodule

// *** core/sap_host.sv ***
// host controller end: apb registers order one byte transfer at a time
// assumes the device answers every selected strobe with its acknowledge
`timescale 1ns/1ps
module sap_host
    import sap_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // link
    sap_link_if.host         lnk
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [1:0] {HO_IDLE, HO_SETUP, HO_WLOW, HO_WHIGH} sap_ho_t;

    sap_ho_t    st_r;
    logic       cd_r;
    logic       rd_r;
    logic [7:0] byte_r;
    logic [7:0] rbyte_r;

    // ----------------------------------------
    // apb decode; always ready, never an error
    // ----------------------------------------
    wire acc     = psel && penable;
    wire hit_ctl = paddr == REG_CTRL;
    wire hit_st  = paddr == REG_STAT;
    // writes while a transfer runs are ignored
    wire start   = acc && pwrite && hit_ctl && (st_r == HO_IDLE);
    wire busy    = st_r != HO_IDLE;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = hit_st ? {14'h0000, lnk.service_request, lnk.end_n, rbyte_r, 7'h00, busy}
                   : hit_ctl ? {16'h0000, byte_r, 6'h00, rd_r, cd_r} : 32'h0000_0000;

    // ----------------------------------------
    // pin drive: select through setup, strobe until acknowledge seen high
    // ----------------------------------------
    wire strobe = (st_r == HO_WLOW) || (st_r == HO_WHIGH);
    assign lnk.cs_n      = !busy;                                                 // RQ1 RQ6
    assign lnk.cd        = cd_r;
    assign lnk.rd_n      = !(strobe && rd_r);                                     // RQ10 RQ12
    assign lnk.wr_n      = !(strobe && !rd_r);
    assign lnk.host_dout = byte_r;
    assign lnk.host_oe_n = !(busy && !rd_r);

    // ----------------------------------------
    // order registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cd_r   <= 1'b0;
            rd_r   <= 1'b0;
            byte_r <= 8'h00;
        end
        else if (start)
        begin
            cd_r   <= pwdata[CTRL_CD];
            rd_r   <= pwdata[CTRL_RD];
            byte_r <= pwdata[CTRL_B_L +: 8];                                      // RQ5 RQ7 RQ19
        end
    end

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= HO_IDLE;
        else
        begin
            unique case (st_r)
                HO_IDLE:  st_r <= start ? HO_SETUP : HO_IDLE;
                HO_SETUP: st_r <= HO_WLOW;
                HO_WLOW:  st_r <= !lnk.ack_n ? HO_WHIGH : HO_WLOW;
                HO_WHIGH: st_r <= lnk.ack_n ? HO_IDLE : HO_WHIGH;                 // RQ1 RQ6
            endcase
        end
    end

    // capture the read byte once acknowledge has returned high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rbyte_r <= 8'h00;
        else if ((st_r == HO_WHIGH) && lnk.ack_n && rd_r)
            rbyte_r <= lnk.host_byte_bus;                                         // RQ10
    end
endmodule

// *** verif/sap_assertions.sv ***
// concurrent checks on the byte link between host controller and coprocessor port
// assumes the testbench wires every strobe and answer input to the shared link interface signals
`timescale 1ns/1ps
module sap_assertions
(
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // host strobes
    input wire logic       cs_n,
    input wire logic       cd,
    input wire logic       rd_n,
    input wire logic       wr_n,
    // device answers
    input wire logic [7:0] dev_dout,
    input wire logic       dev_oe_n,
    input wire logic       ack_n,
    input wire logic       end_n
);
    // ------------------------------------------------------------
    // link handshake
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // acknowledge rests high unless a selected strobe is low
    AST_ACK_IDLE: assert property (cs_n || (rd_n && wr_n) |-> ack_n)
        else $error("ack low without a selected strobe");
    // a fresh selected strobe pulls acknowledge low at once
    AST_ACK_LOW: assert property (!cs_n && ($fell(wr_n) || $fell(rd_n)) |-> !ack_n)
        else $error("strobe fell but ack stayed high");
    // once acknowledged, ack is still high one cycle later if the strobe is still held
    AST_ACK_HOLDS: assert property ($rose(ack_n) && !cs_n && !(rd_n && wr_n) |=> ack_n || cs_n || (rd_n && wr_n))
        else $error("ack fell again before strobe release");
    // device never drives the lane during a write
    AST_WR_QUIET: assert property (!wr_n |-> dev_oe_n)
        else $error("device drives lane during write");
    // read byte is on the lane when ack rises
    AST_RD_DRIVE: assert property ($rose(ack_n) && !cs_n && !rd_n |-> !dev_oe_n)
        else $error("read acknowledged without byte driven");
    // read byte stays put for as long as it is on the lane
    AST_RD_HOLD: assert property (!cs_n && !rd_n && !dev_oe_n |=> $stable(dev_dout) && (rd_n || cs_n || !dev_oe_n))
        else $error("read byte changed during strobe");

    // ------------------------------------------------------------
    // command execution and end of execution
    // ------------------------------------------------------------
    // a taken command ends after the fixed execution time
    AST_EXEC_END: assert property (!cs_n && cd && !wr_n && !ack_n ##1 ack_n |-> end_n ##[14:17] !end_n)
        else $error("command end not seen in time");
    // transfers other than status reads are held for eight cycles after a command is acknowledged
    AST_BUSY_HOLD: assert property (!cs_n && cd && !wr_n && !ack_n ##1 ack_n |-> ##1 (cs_n || (wr_n && (rd_n || cd)) || !ack_n)[*8])
        else $error("transfer acknowledged during execution");
    // a status read releases the end of execution output
    AST_END_CLR: assert property (!cs_n && cd && !rd_n && !ack_n && !end_n |=> end_n)
        else $error("status read left end low");
endmodule

// *** verif/tb.sv ***
// self-checking bench: apb host controller and coprocessor port joined by the byte link
// assumes the design package, link interface and checker are compiled first
`timescale 1ns/1ps
module tb
    import sap_pkg::*;
;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    integer      seed = 65776;
    logic [6:0]  op;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] e;
    logic        sr;
    logic [3:0]  err;
    logic [7:0]  q;
    logic [31:0] v;
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] st;
    logic [7:0]  p [18];
    logic [6:0]  ops16 [5] = '{OP_SADD, OP_SSUB, OP_SMUL, OP_SMUU, OP_SDIV};

    sap_link_if lnk_if ();
    sap_dev sap_dev_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk_if));
    sap_host sap_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk_if));
    sap_assertions sap_assertions_inst (.pclk(pclk), .presetn(presetn), .cs_n(lnk_if.cs_n), .cd(lnk_if.cd),
        .rd_n(lnk_if.rd_n), .wr_n(lnk_if.wr_n), .dev_dout(lnk_if.dev_dout), .dev_oe_n(lnk_if.dev_oe_n),
        .ack_n(lnk_if.ack_n), .end_n(lnk_if.end_n));

    // free running clock and hang guard
    always #4 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // one link transfer ordered through the controller, then poll until done
    task automatic link(input logic c, input logic r, input logic [7:0] bt, output logic [7:0] rb);
        logic [31:0] s;
        apb(1'b1, REG_CTRL, {16'h0000, bt, 6'h00, r, c}, s);
        do
            apb(1'b0, REG_STAT, 32'h0000_0000, s);
        while (s[0] !== 1'b0);
        rb = s[15:8];
    endtask

    task automatic wait_end(input logic srq);
        logic [31:0] s;
        do
            apb(1'b0, REG_STAT, 32'h0000_0000, s);
        while (s[STAT_END] !== 1'b0);
        chk("service request", 32'(s[STAT_SVC]), 32'(srq));
    endtask

    task automatic push(input int n, input logic [31:0] d);
        logic [7:0] rb;
        for (int i = 0; i < n; i++)
            link(1'b0, 1'b0, d[8*i +: 8], rb);
    endtask

    task automatic pop(input int n, output logic [31:0] d);
        logic [7:0] rb;
        d = 32'h0000_0000;
        for (int i = 0; i < n; i++)
        begin
            link(1'b0, 1'b1, 8'h00, rb);
            d = {d[23:0], rb};
        end
    endtask

    // expected 16-bit result, nxt operand first, top operand second
    function automatic logic [15:0] f16(input logic [6:0] o, input logic [15:0] n, input logic [15:0] t);
        logic signed [31:0] pr;
        pr = $signed(n) * $signed(t);
        case (o)
            OP_SADD: f16 = n + t;
            OP_SSUB: f16 = n - t;
            OP_SMUL: f16 = pr[15:0];
            OP_SMUU: f16 = pr[31:16];
            default: f16 = (t == 16'h0000) ? n : 16'($signed(n) / $signed(t));
        endcase
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_STAT, 32'h0000_0000, st);
        chk("reset status", st & 32'h0003_0001, 32'h0001_0000);
        apb(1'b1, 8'h08, 32'($random(seed)), st);
        apb(1'b0, 8'h08, 32'h0000_0000, st);
        chk("unmapped", st, 32'h0000_0000);
        $display("test reset done");
        for (int k = 0; k < 10; k++)
        begin
            op = ops16[k % 5];
            a = 16'($random(seed));
            b = (k == 9) ? 16'h0000 : 16'($random(seed));
            sr = 1'($random(seed));
            push(2, {16'h0000, a});
            push(2, {16'h0000, b});
            link(1'b1, 1'b0, {sr, op}, q);
            wait_end(sr);
            e = f16(op, a, b);
            err = (op == OP_SDIV && b == 16'h0000) ? ERR_DIV0 : ERR_NONE;
            link(1'b1, 1'b1, 8'h00, q);
            chk("status", 32'(q & 8'hfe), 32'({1'b0, e[15], (e == 16'h0000), err, 1'b0}));
            apb(1'b0, REG_STAT, 32'h0000_0000, st);
            chk("end after status", 32'(st[STAT_END]), 32'h0000_0001);
            pop(2, v);
            chk("result16", v, {16'h0000, e});
        end
        $display("test fixed16 done");
        for (int k = 0; k < 3; k++)
        begin
            x = 32'($random(seed)) | 32'h0080_0000;
            y = 32'($random(seed));
            op = (k == 0) ? OP_DADD : ((k == 1) ? OP_DSUB : OP_CHSF);
            push(4, x);
            if (k < 2)
                push(4, y);
            link(1'b1, 1'b0, {1'b1, op}, q);
            wait_end(1'b1);
            pop(4, v);
            chk("result32", v, (k == 0) ? x + y : ((k == 1) ? x - y : x ^ (32'h0000_0001 << FP_SIGN)));
        end
        $display("test fixed32 float done");
        a = 16'($random(seed));
        b = 16'($random(seed));
        push(2, {16'h0000, a});
        push(2, {16'h0000, b});
        link(1'b1, 1'b0, {1'b0, OP_SADD}, q);
        link(1'b1, 1'b0, {1'b0, OP_NOP}, q);
        link(1'b1, 1'b1, 8'h00, q);
        chk("busy status", 32'(q[ST_BUSY]), 32'h0000_0001);
        pop(2, v);
        chk("held pop", v, {16'h0000, a + b});
        wait_end(1'b0);
        $display("test overlap done");
        for (int i = 0; i < 18; i++)
        begin
            p[i] = 8'($random(seed));
            link(1'b0, 1'b0, p[i], q);
        end
        for (int i = 0; i < 17; i++)
        begin
            link(1'b0, 1'b1, 8'h00, q);
            chk("stack byte", 32'(q), 32'(p[(i < 16) ? 17 - i : 17]));
        end
        $display("test wrap done");
        stop_test();
    end
endmodule
